// ===== logic/smist_top.sv
// Contract
// - Status bits report pending interrupt sources
// - Bit0 mouse, cleared only at source
// - Bit1 keyboard, cleared only at source
// - Bit2 set by selected infrared edge
// - Infrared bit cleared by register read
// - Bit4 controller port, others reserved
// - Gpio a maps pins, bit3 reserved
// - Gpio b maps eight pins
// - Gpio c fifty group, bits4-5 reserved
// - Gpio bits write one clears
// - All status registers reset to zero
`timescale 1ns/10ps
`default_nettype none
module smist_top (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wr_data,
  input  wire logic        i_wr_en,
  input  wire logic        i_rd_en,
  output logic      [7:0]  o_rd_data,
  output logic             o_irq,
  input  wire logic        i_mouse_irq_flag,
  input  wire logic        i_keyboard_irq_flag,
  input  wire logic        i_kbc_port_out_flag,
  input  wire logic        i_second_serial_receive,
  input  wire logic        i_alt_infrared_receive,
  input  wire logic [7:0]  i_gpio_a_event,
  input  wire logic [7:0]  i_gpio_b_event,
  input  wire logic [7:0]  i_gpio_c_event
);

  localparam int N = smist_pkg::NUM_STAT;

  smist_if sif[N] ();

  logic [N-1:0][7:0] set_vec;
  logic [N-1:0][7:0] level_vec;
  logic [N-1:0][7:0] w1c_vec;
  logic [N-1:0]      rdclr_vec;
  logic [N-1:0][7:0] stat_vec;

  logic [7:0]        config_q;
  logic [7:0]        config_d;
  logic [N-1:0][7:0] mask_q;
  logic [N-1:0][7:0] mask_d;
  logic [7:0]        rd_data_q;
  logic [7:0]        rd_data_d;
  logic              irq_q;
  logic              irq_d;
  logic              ir_prev_q;
  logic              ir_valid_q;

  // Address decode
  wire               hit_internal;
  wire               hit_gpio_a;
  wire               hit_gpio_b;
  wire               hit_gpio_c;
  wire               hit_config;
  wire [N-1:0]       hit_mask;
  wire [N-1:0]       hit_stat;

  assign hit_internal = (i_addr == smist_pkg::OFF_INTERNAL);
  assign hit_gpio_a   = (i_addr == smist_pkg::OFF_GPIO_A);
  assign hit_gpio_b   = (i_addr == smist_pkg::OFF_GPIO_B);
  assign hit_gpio_c   = (i_addr == smist_pkg::OFF_GPIO_C);
  assign hit_config   = (i_addr == smist_pkg::OFF_CONFIG);
  assign hit_mask[0]  = (i_addr == smist_pkg::OFF_MASK_INT);
  assign hit_mask[1]  = (i_addr == smist_pkg::OFF_MASK_A);
  assign hit_mask[2]  = (i_addr == smist_pkg::OFF_MASK_B);
  assign hit_mask[3]  = (i_addr == smist_pkg::OFF_MASK_C);
  assign hit_stat     = {hit_gpio_c, hit_gpio_b, hit_gpio_a, hit_internal};

  // Infrared receive selection and transition detection
  wire               ir_select;
  wire               ir_selected;
  wire               ir_edge;

  assign ir_select   = config_q[smist_pkg::BIT_IR_SELECT];
  assign ir_selected = ir_select ? i_alt_infrared_receive : i_second_serial_receive;
  // First sample after reset or a mux switch has no history; no edge then
  assign ir_edge     = ir_valid_q & (ir_selected != ir_prev_q);

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      ir_prev_q  <= 1'b0;
      ir_valid_q <= 1'b0;
    end
    else
    begin
      ir_prev_q  <= ir_selected;
      ir_valid_q <= ~(i_wr_en & hit_config & (i_wr_data[smist_pkg::BIT_IR_SELECT] != ir_select));
    end
  end

  // Source wiring into the internal and gpio registers
  always_comb
  begin
    set_vec   = '0;
    level_vec = '0;
    level_vec[0][smist_pkg::BIT_MOUSE]    = i_mouse_irq_flag;
    level_vec[0][smist_pkg::BIT_KEYBOARD] = i_keyboard_irq_flag;
    level_vec[0][smist_pkg::BIT_KBC_PORT] = i_kbc_port_out_flag;
    set_vec[0][smist_pkg::BIT_INFRARED]   = ir_edge;
    set_vec[1] = i_gpio_a_event;
    set_vec[2] = i_gpio_b_event;
    set_vec[3] = i_gpio_c_event;
  end

  // Write-one-clear and read-clear strobes
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_stat
      assign w1c_vec[g]   = (i_wr_en & hit_stat[g]) ? i_wr_data : 8'h00;
      assign rdclr_vec[g] = i_rd_en & hit_stat[g];

      assign sif[g].set   = set_vec[g];
      assign sif[g].level = level_vec[g];
      assign sif[g].w1c   = w1c_vec[g];
      assign sif[g].rdclr = rdclr_vec[g];
      assign stat_vec[g]  = sif[g].value;

      smist_stat_reg #(
        .LEVEL_MASK (smist_pkg::LEVEL_MASKS[g]),
        .RDCLR_MASK (smist_pkg::RDCLR_MASKS[g]),
        .W1C_MASK   (smist_pkg::W1C_MASKS[g])
      ) u_stat (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .port       (sif[g].stat)
      );

      assign mask_d[g] = (i_wr_en & hit_mask[g])
                         ? (i_wr_data & (smist_pkg::LEVEL_MASKS[g]
                                         | smist_pkg::RDCLR_MASKS[g]
                                         | smist_pkg::W1C_MASKS[g]))
                         : mask_q[g];
    end
  endgenerate

  // Configuration and mask storage
  assign config_d = (i_wr_en & hit_config)
                    ? (i_wr_data & smist_pkg::CONFIG_MASK)
                    : config_q;

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      config_q <= smist_pkg::CONFIG_RESET;
    else
      config_q <= config_d;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      mask_q <= {N{smist_pkg::MASK_RESET}};
    else
      mask_q <= mask_d;
  end

  // Read path: value seen before any read-clear of the same cycle
  wire [7:0] rd_mux;

  assign rd_mux = hit_internal  ? stat_vec[0] :
                  hit_gpio_a    ? stat_vec[1] :
                  hit_gpio_b    ? stat_vec[2] :
                  hit_gpio_c    ? stat_vec[3] :
                  hit_config    ? config_q    :
                  hit_mask[0]   ? mask_q[0]   :
                  hit_mask[1]   ? mask_q[1]   :
                  hit_mask[2]   ? mask_q[2]   :
                  hit_mask[3]   ? mask_q[3]   :
                  smist_pkg::UNMAPPED_READ;

  // Data valid only in the cycle after the strobe
  assign rd_data_d = i_rd_en ? rd_mux : 8'h00;

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      rd_data_q <= 8'h00;
    else
      rd_data_q <= rd_data_d;
  end

  // Interrupt: any unmasked pending bit, one cycle behind the status
  wire [N-1:0] reg_pending;

  generate
    for (g = 0; g < N; g++)
    begin : g_irq
      assign reg_pending[g] = |(stat_vec[g] & mask_q[g]);
    end
  endgenerate

  assign irq_d = |reg_pending;

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      irq_q <= 1'b0;
    else
      irq_q <= irq_d;
  end

  assign o_rd_data = rd_data_q;
  assign o_irq     = irq_q;

endmodule
`default_nettype wire

// ===== inc/smist_pkg.sv
`default_nettype none
package smist_pkg;

  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam int          NUM_STAT        = 4;

  // Status register offsets
  localparam logic [7:0]  OFF_INTERNAL    = 8'h11;
  localparam logic [7:0]  OFF_GPIO_A      = 8'h12;
  localparam logic [7:0]  OFF_GPIO_B      = 8'h13;
  localparam logic [7:0]  OFF_GPIO_C      = 8'h14;
  // Configuration and interrupt mask offsets
  localparam logic [7:0]  OFF_CONFIG      = 8'h20;
  localparam logic [7:0]  OFF_MASK_INT    = 8'h21;
  localparam logic [7:0]  OFF_MASK_A      = 8'h22;
  localparam logic [7:0]  OFF_MASK_B      = 8'h23;
  localparam logic [7:0]  OFF_MASK_C      = 8'h24;

  // Field positions in the internal register
  localparam int          BIT_MOUSE       = 0;
  localparam int          BIT_KEYBOARD    = 1;
  localparam int          BIT_INFRARED    = 2;
  localparam int          BIT_KBC_PORT    = 4;
  // Field positions in the configuration register
  localparam int          BIT_IR_SELECT   = 0;
  localparam logic [7:0]  CONFIG_MASK     = 8'h01;

  localparam logic [7:0]  STAT_RESET      = 8'h00;
  localparam logic [7:0]  MASK_RESET      = 8'h00;
  localparam logic [7:0]  CONFIG_RESET    = 8'h00;
  localparam logic [7:0]  UNMAPPED_READ   = 8'h00;

  // Per register: index 0 internal, 1..3 gpio a..c
  localparam logic [3:0][7:0] LEVEL_MASKS = {8'h00, 8'h00, 8'h00, 8'h13};
  localparam logic [3:0][7:0] RDCLR_MASKS = {8'h00, 8'h00, 8'h00, 8'h04};
  localparam logic [3:0][7:0] W1C_MASKS   = {8'hcf, 8'hff, 8'hf7, 8'h00};

endpackage
`default_nettype wire

// ===== inc/smist_if.sv
`timescale 1ns/10ps
`default_nettype none
interface smist_if;
  logic [7:0] set;
  logic [7:0] level;
  logic [7:0] w1c;
  logic       rdclr;
  logic [7:0] value;

  modport ctl  (output set, output level, output w1c, output rdclr, input value);
  modport stat (input set, input level, input w1c, input rdclr, output value);
endinterface
`default_nettype wire

// ===== logic/smist_stat_reg.sv
`timescale 1ns/10ps
`default_nettype none
module smist_stat_reg #(
  parameter logic [7:0] LEVEL_MASK = 8'h00,
  parameter logic [7:0] RDCLR_MASK = 8'h00,
  parameter logic [7:0] W1C_MASK   = 8'h00
) (
  input  wire logic   i_core_clk,
  input  wire logic   i_rst,
  smist_if.stat       port
);

  localparam logic [7:0] STICKY_MASK = RDCLR_MASK | W1C_MASK;
  localparam logic [7:0] VALID_MASK  = STICKY_MASK | LEVEL_MASK;

  generate
    if ((LEVEL_MASK & STICKY_MASK) != 8'h00)
    begin : g_bad_masks
      $error("smist_stat_reg: a bit cannot be both level and sticky");
    end
  endgenerate

  logic [7:0] value_q;
  logic [7:0] value_d;
  wire  [7:0] clr_bits;
  wire  [7:0] sticky_next;

  assign clr_bits    = (port.w1c & W1C_MASK) | ({8{port.rdclr}} & RDCLR_MASK);
  // Set beats clear so an event in the clear cycle survives
  assign sticky_next = ((value_q & ~clr_bits) | port.set) & STICKY_MASK;

  assign value_d     = (sticky_next | (port.level & LEVEL_MASK)) & VALID_MASK;

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
      value_q <= smist_pkg::STAT_RESET;
    else
      value_q <= value_d;
  end

  assign port.value = value_q;

endmodule
`default_nettype wire

// ===== tb/smist_properties.sv
`timescale 1ns/10ps
`default_nettype none
module smist_chk (
  input wire logic       i_core_clk,
  input wire logic       i_rst,
  input wire logic [7:0] i_addr,
  input wire logic       i_rd_en,
  input wire logic [7:0] o_rd_data,
  input wire logic       o_irq,
  input wire logic       i_mouse_irq_flag,
  input wire logic       i_keyboard_irq_flag,
  input wire logic       i_kbc_port_out_flag,
  input wire logic [7:0] i_gpio_b_event
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  wire logic rd11 = i_rd_en && i_addr == 8'h11;
  a_reset_clean: assert property ($past(i_rst)
    |-> o_rd_data == 8'h00 && !o_irq) else $error("not clean after reset");
  // Level bits lag the source by one edge
  a_mouse_level: assert property (rd11 && !$past(i_rst)
    |=> o_rd_data[0] == $past(i_mouse_irq_flag, 2)) else $error("mouse bit");
  a_kbd_level: assert property (rd11 && !$past(i_rst)
    |=> o_rd_data[1] == $past(i_keyboard_irq_flag, 2)) else $error("keyboard bit");
  a_kbc_level: assert property (rd11 && !$past(i_rst)
    |=> o_rd_data[4] == $past(i_kbc_port_out_flag, 2)) else $error("kbc bit");
  a_rsvd_internal: assert property (rd11
    |=> o_rd_data[3] == 1'b0 && o_rd_data[7:5] == 3'h0) else $error("internal reserved");
  a_rsvd_gpio_a: assert property (i_rd_en && i_addr == 8'h12
    |=> o_rd_data[3] == 1'b0) else $error("gpio a reserved");
  a_rsvd_gpio_c: assert property (i_rd_en && i_addr == 8'h14
    |=> o_rd_data[5:4] == 2'h0) else $error("gpio c reserved");
  a_gpio_b_set: assert property (i_rd_en && i_addr == 8'h13 && !$past(i_rst)
    |=> (o_rd_data & $past(i_gpio_b_event, 2)) == $past(i_gpio_b_event, 2))
    else $error("gpio b not set");
  a_unmapped_zero: assert property (i_rd_en && i_addr == 8'h30
    |=> o_rd_data == 8'h00) else $error("unmapped read");
endmodule
bind smist_top smist_chk u_chk (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
  .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .o_irq(o_irq),
  .i_mouse_irq_flag(i_mouse_irq_flag), .i_keyboard_irq_flag(i_keyboard_irq_flag),
  .i_kbc_port_out_flag(i_kbc_port_out_flag), .i_gpio_b_event(i_gpio_b_event));
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, irq;
  logic       mo = 1'b0, kb = 1'b0, kc = 1'b0, ir0 = 1'b0, ir1 = 1'b0;
  logic [7:0] ad = 8'h00, wd = 8'h00, rdat, ga = 8'h00, gb = 8'h00, gc = 8'h00;
  int         err_total = 0, checks_done = 0;
  smist_top u_smist_top (.i_core_clk(clk), .i_rst(rst), .i_addr(ad), .i_wr_data(wd),
    .i_wr_en(wr), .i_rd_en(rd), .o_rd_data(rdat), .o_irq(irq), .i_mouse_irq_flag(mo),
    .i_keyboard_irq_flag(kb), .i_kbc_port_out_flag(kc), .i_second_serial_receive(ir0),
    .i_alt_infrared_receive(ir1), .i_gpio_a_event(ga), .i_gpio_b_event(gb),
    .i_gpio_c_event(gc));
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wrt(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    ad <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe; taken at its closing edge
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    ad <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    chk($sformatf("reg %h", a), e, rdat);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #5000;
    err_total++;
    summarize();
  end
  initial
  begin
    idle(8);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) rdc(8'h11 + i[7:0], 8'h00);
    rdc(8'h30, 8'h00);
    mo <= 1'b1;
    kb <= 1'b1;
    kc <= 1'b1;
    idle(2);
    rdc(8'h11, 8'h13);
    wrt(8'h11, 8'hff);
    rdc(8'h11, 8'h13);
    mo <= 1'b0;
    kb <= 1'b0;
    kc <= 1'b0;
    idle(2);
    rdc(8'h11, 8'h00);
    ir0 <= 1'b1;
    idle(3);
    rdc(8'h11, 8'h04);
    rdc(8'h11, 8'h00);
    ir1 <= 1'b1;
    idle(3);
    rdc(8'h11, 8'h00);
    // Pins equal before switching, so no edge from the mux
    wrt(8'h20, 8'h01);
    idle(2);
    ir1 <= 1'b0;
    idle(3);
    rdc(8'h11, 8'h04);
    rdc(8'h11, 8'h00);
    ga <= 8'hff;
    gb <= 8'hff;
    gc <= 8'hff;
    idle(1);
    ga <= 8'h00;
    gb <= 8'h00;
    gc <= 8'h00;
    rdc(8'h12, 8'hf7);
    rdc(8'h13, 8'hff);
    rdc(8'h14, 8'hcf);
    wrt(8'h12, 8'h0f);
    rdc(8'h12, 8'hf0);
    wrt(8'h13, 8'h00);
    rdc(8'h13, 8'hff);
    wrt(8'h14, 8'hff);
    rdc(8'h14, 8'h00);
    wrt(8'h12, 8'hff);
    wrt(8'h22, 8'h01);
    rdc(8'h22, 8'h01);
    ga <= 8'h09;
    idle(1);
    ga <= 8'h00;
    idle(2);
    chk("irq", 8'h01, {7'h00, irq});
    rdc(8'h12, 8'h01);
    wrt(8'h22, 8'h00);
    idle(2);
    chk("irq", 8'h00, {7'h00, irq});
    wrt(8'h22, 8'h01);
    idle(2);
    chk("irq", 8'h01, {7'h00, irq});
    wrt(8'h12, 8'h01);
    idle(2);
    chk("irq", 8'h00, {7'h00, irq});
    // Event held through the clear: set wins
    gb <= 8'h81;
    wrt(8'h13, 8'hff);
    rdc(8'h13, 8'h81);
    gb <= 8'h00;
    wrt(8'h13, 8'hff);
    rdc(8'h13, 8'h00);
    // Only valid internal bits take a mask
    wrt(8'h21, 8'hff);
    rdc(8'h21, 8'h17);
    mo <= 1'b1;
    idle(3);
    chk("irq", 8'h01, {7'h00, irq});
    mo <= 1'b0;
    idle(3);
    chk("irq", 8'h00, {7'h00, irq});
    // Pins differ across the switch; the mux glitch must not set the flag
    wrt(8'h20, 8'h00);
    idle(2);
    rdc(8'h11, 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
